// ===== hdl/adcc_ctrl.sv
// Control logic of a pipelined converter: registers, sequencer, events.
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module adcc_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [7:0]  rdata,
	output logic             irq,
	input  wire logic        ev_trig_i,
	output logic      [3:0]  ev_done_o,
	output logic             sample_o,
	output logic      [3:0]  pos_o,
	output logic      [2:0]  neg_o,
	output logic      [1:0]  cfg_o,
	output logic             powered_o,
	input  wire logic        res_valid_i,
	input  wire logic [11:0] res_data_i,
	output logic      [3:0]  dma_req_o,
	input  wire logic        dma_rd_i,
	input  wire logic [1:0]  dma_ch_i,
	output logic      [11:0] dma_data_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_OFF  = 4'b0001,
		S_WARM = 4'b0010,
		S_IDLE = 4'b0100,
		S_BUSY = 4'b1000
	} adcc_state_t;

	typedef struct packed {
		adcc_state_t     st;
		logic            en;
		logic            cont;
		logic            ev_en;
		logic            ev_sweep;
		logic [1:0]      ev_ch;
		logic [3:0][1:0] cfg;
		logic [3:0][7:0] insel;
		logic [3:0][11:0] res;
		logic [3:0]      flags;
		logic [3:0]      istat;
		logic [3:0]      imask;
		logic [3:0]      pend;
		logic [4:0]      cnt;
		logic [1:0]      cur;
		logic [7:0]      rdata;
		logic            irq;
		logic            sample;
		logic [3:0]      pos;
		logic [2:0]      neg;
		logic [1:0]      cmode;
		logic [3:0]      ev_done;
		logic [3:0]      dma_req;
		logic [11:0]     dma_data;
	} adcc_regs_t;

	adcc_regs_t s_q;
	adcc_regs_t s_d;

	function automatic logic [1:0] adcc_first(input logic [3:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (v[i]) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] adcc_onehot(input logic [1:0] c);
		return 4'h1 << c;
	endfunction

	logic       ch_hit;
	logic [1:0] ch_sel;
	logic       done;
	assign ch_hit = addr[7:4] == adcc_pkg::CH_PAGE;
	assign ch_sel = addr[3:2];
	assign done   = (s_q.st == S_BUSY) && res_valid_i;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.sample = 1'b0;
		s_d.ev_done = 4'h0;
		s_d.rdata = 8'h00;
		// Clears come first so that a same-cycle set wins.
		if (wr && addr == adcc_pkg::A_DONE_FLAGS) begin
			s_d.flags = s_q.flags & ~wdata[3:0];
		end
		if (dma_rd_i) begin
			s_d.dma_req[dma_ch_i] = 1'b0;
			s_d.dma_data = s_q.res[dma_ch_i];
		end
		if (rd) begin
			if (ch_hit) begin
				unique case (addr[1:0])
				adcc_pkg::SUB_CFG: s_d.rdata = {6'h00, s_q.cfg[ch_sel]};
				adcc_pkg::SUB_INSEL: s_d.rdata = s_q.insel[ch_sel];
				adcc_pkg::SUB_RES_LOW: s_d.rdata = s_q.res[ch_sel][7:0];
				adcc_pkg::SUB_RES_HIGH:
					s_d.rdata = {4'h0, s_q.res[ch_sel][11:8]};
				endcase
			end else begin
				case (addr)
				adcc_pkg::A_FIRST_CTRL: s_d.rdata = {7'h00, s_q.en};
				adcc_pkg::A_SECOND_CTRL:
					s_d.rdata = 8'(s_q.cont) << adcc_pkg::CONT_BIT;
				adcc_pkg::A_EVENT_CTRL:
					s_d.rdata = {4'h0, s_q.ev_ch, s_q.ev_sweep, s_q.ev_en};
				adcc_pkg::A_DONE_FLAGS: s_d.rdata = {4'h0, s_q.flags};
				adcc_pkg::A_IRQ_STATUS: begin
					s_d.rdata = {4'h0, s_q.istat};
					s_d.istat = 4'h0;
				end
				adcc_pkg::A_IRQ_MASK: s_d.rdata = {4'h0, s_q.imask};
				default: s_d.rdata = 8'h00;
				endcase
			end
		end
		if (wr) begin
			if (ch_hit) begin
				if (addr[1:0] == adcc_pkg::SUB_CFG) begin
					s_d.cfg[ch_sel] = wdata[1:0];
				end
				if (addr[1:0] == adcc_pkg::SUB_INSEL) begin
					s_d.insel[ch_sel] = wdata;
				end
			end else begin
				case (addr)
				adcc_pkg::A_FIRST_CTRL: begin
					s_d.en = wdata[adcc_pkg::EN_BIT];
					if (s_q.en) begin
						s_d.pend = s_q.pend | wdata[5:2];
					end
				end
				adcc_pkg::A_SECOND_CTRL:
					s_d.cont = wdata[adcc_pkg::CONT_BIT];
				adcc_pkg::A_EVENT_CTRL: begin
					s_d.ev_en = wdata[adcc_pkg::EV_EN_BIT];
					s_d.ev_sweep = wdata[adcc_pkg::EV_SWEEP_BIT];
					s_d.ev_ch = wdata[adcc_pkg::EV_CH_LSB +: 2];
				end
				adcc_pkg::A_IRQ_MASK: s_d.imask = wdata[3:0];
				default: ;
				endcase
			end
		end
		if (ev_trig_i && s_q.ev_en && s_q.en) begin
			if (s_q.ev_sweep) begin
				s_d.pend = 4'hf;
			end else begin
				s_d.pend = s_d.pend | adcc_onehot(s_q.ev_ch);
			end
		end
		if (s_d.cont && s_d.en) begin
			s_d.pend[0] = 1'b1;
		end
		unique case (s_q.st)
		S_OFF: begin
			s_d.cnt = 5'h00;
			if (s_q.en) begin
				s_d.st = S_WARM;
			end
		end
		S_WARM: begin
			s_d.cnt = s_q.cnt + 5'h01;
			if (s_q.cnt == adcc_pkg::STARTUP_LAST) begin
				s_d.st = S_IDLE;
			end
		end
		S_IDLE: begin
			if (s_q.pend != 4'h0) begin
				s_d.cur = adcc_first(s_q.pend);
				s_d.pend[s_d.cur] = 1'b0;
				s_d.pos = s_q.insel[s_d.cur][adcc_pkg::POS_LSB +: 4];
				s_d.neg = s_q.insel[s_d.cur][adcc_pkg::NEG_LSB +: 3];
				s_d.cmode = s_q.cfg[s_d.cur];
				if (s_q.cfg[s_d.cur] == adcc_pkg::MODE_SINGLE) begin
					s_d.neg = 3'h0;
				end
				s_d.sample = 1'b1;
				s_d.st = S_BUSY;
			end
		end
		S_BUSY: begin
			if (res_valid_i) begin
				s_d.res[s_q.cur] = res_data_i;
				s_d.flags[s_q.cur] = 1'b1;
				s_d.istat[s_q.cur] = 1'b1;
				s_d.ev_done[s_q.cur] = 1'b1;
				s_d.dma_req[s_q.cur] = 1'b1;
				s_d.st = S_IDLE;
			end
		end
		endcase
		if (!s_q.en) begin
			s_d.st = S_OFF;
			s_d.pend = 4'h0;
		end
		s_d.irq = |(s_d.istat & s_d.imask);
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.st <= S_OFF;
			s_q.cfg <= {4{adcc_pkg::CFG_RESET}};
			s_q.insel <= {4{adcc_pkg::INSEL_RESET}};
		end else begin
			s_q <= s_d;
		end
	end

	assign rdata = s_q.rdata;
	assign irq = s_q.irq;
	assign ev_done_o = s_q.ev_done;
	assign sample_o = s_q.sample;
	assign pos_o = s_q.pos;
	assign neg_o = s_q.neg;
	assign cfg_o = s_q.cmode;
	assign powered_o = s_q.en;
	assign dma_req_o = s_q.dma_req;
	assign dma_data_o = s_q.dma_data;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence q_warm_start;
		$rose(s_q.st == S_WARM);
	endsequence
	sequence q_done0;
		done && s_q.cur == 2'h0;
	endsequence
	sequence q_idle_cont;
		s_q.st == S_IDLE && s_q.cont && s_q.en;
	endsequence

	property p_startup;
		@(posedge clk_sys) disable iff (sys_rst)
		q_warm_start |-> (!sample_o) [*8] ##16 (s_q.st == S_WARM)
			##1 (s_q.st != S_WARM);
	endproperty
	a_startup: assert property (p_startup)
		else $error("Start-up interval is not 24 clocks.");

	property p_continuous_convert_bit;
		@(posedge clk_sys) disable iff (sys_rst)
		q_idle_cont ##1 s_q.en |-> sample_o;
	endproperty
	a_continuous_convert_bit: assert property (p_continuous_convert_bit)
		else $error("Continuous mode did not relaunch.");

	property p_inputs;
		@(posedge clk_sys) disable iff (sys_rst)
		sample_o && cfg_o == adcc_pkg::MODE_DIFF |->
			pos_o == s_q.insel[s_q.cur][6:3] &&
			neg_o == s_q.insel[s_q.cur][2:0];
	endproperty
	a_inputs: assert property (p_inputs)
		else $error("Input select does not match channel.");

	property p_single;
		@(posedge clk_sys) disable iff (sys_rst)
		sample_o && cfg_o == adcc_pkg::MODE_SINGLE |-> neg_o == 3'h0;
	endproperty
	a_single: assert property (p_single)
		else $error("Single-ended conversion drove a negative input.");

	property p_flag_set;
		@(posedge clk_sys) disable iff (sys_rst)
		q_done0 |=> s_q.flags[0] && ev_done_o[0];
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("Completion did not set flag and event.");

	property p_w1c;
		@(posedge clk_sys) disable iff (sys_rst)
		wr && addr == adcc_pkg::A_DONE_FLAGS && !done |=>
			s_q.flags == ($past(s_q.flags) & ~$past(wdata[3:0]));
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("Flag write did not act as write-one-to-clear.");

	property p_result;
		@(posedge clk_sys) disable iff (sys_rst)
		done |=> s_q.res[$past(s_q.cur)] == $past(res_data_i);
	endproperty
	a_result: assert property (p_result)
		else $error("Result pair not updated with latest conversion.");

	property p_start;
		@(posedge clk_sys) disable iff (sys_rst)
		wr && addr == adcc_pkg::A_FIRST_CTRL && wdata[2] && wdata[0] &&
		s_q.st == S_IDLE && s_q.pend == 4'h0 && !ev_trig_i && !s_q.cont
		|-> ##2 sample_o && s_q.cur == 2'h0;
	endproperty
	a_start: assert property (p_start)
		else $error("Start request did not launch a conversion.");

	property p_sweep;
		@(posedge clk_sys) disable iff (sys_rst)
		ev_trig_i && s_q.ev_en && s_q.ev_sweep && s_q.en &&
		(s_q.st != S_IDLE || s_q.pend == 4'h0) |=> s_q.pend == 4'hf;
	endproperty
	a_sweep: assert property (p_sweep)
		else $error("Sweep event did not request all channels.");

	property p_dma;
		@(posedge clk_sys) disable iff (sys_rst)
		dma_rd_i |=> dma_data_o == $past(s_q.res[dma_ch_i]);
	endproperty
	a_dma: assert property (p_dma)
		else $error("Direct access read returned a wrong result.");
endmodule
`default_nettype wire

// ===== hdl/adcc_pkg.sv
// Constants for the converter control block: offsets, fields, resets, timing.
package adcc_pkg;
	localparam int NCH = 4;
	localparam int RW  = 12;
	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] A_FIRST_CTRL  = 8'h00;
	localparam logic [7:0] A_SECOND_CTRL = 8'h01;
	localparam logic [7:0] A_EVENT_CTRL  = 8'h02;
	localparam logic [7:0] A_DONE_FLAGS  = 8'h03;
	localparam logic [7:0] A_IRQ_STATUS  = 8'h04;
	localparam logic [7:0] A_IRQ_MASK    = 8'h05;
	localparam logic [3:0] CH_PAGE       = 4'h1;
	localparam logic [1:0] SUB_CFG       = 2'h0;
	localparam logic [1:0] SUB_INSEL     = 2'h1;
	localparam logic [1:0] SUB_RES_LOW   = 2'h2;
	localparam logic [1:0] SUB_RES_HIGH  = 2'h3;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int EN_BIT       = 0;
	localparam int START_LSB    = 2;
	localparam int CONT_BIT     = 3;
	localparam int EV_EN_BIT    = 0;
	localparam int EV_SWEEP_BIT = 1;
	localparam int EV_CH_LSB    = 2;
	localparam int POS_LSB      = 3;
	localparam int NEG_LSB      = 0;
	// ----------------------------------------------------------------
	// Input configurations and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_INTERNAL = 2'h0;
	localparam logic [1:0] MODE_SINGLE   = 2'h1;
	localparam logic [1:0] MODE_DIFF     = 2'h2;
	localparam logic [7:0] INSEL_RESET   = 8'h00;
	localparam logic [1:0] CFG_RESET     = 2'h0;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         STARTUP_CLKS = 24;
	localparam logic [4:0] STARTUP_LAST = 5'(STARTUP_CLKS - 1);
endpackage

// ===== sim/adcc_fe_model.sv
// Behavioural analog front end that answers each convert request.
`timescale 1ns/100ps
`default_nettype none
module adcc_fe_model (
	input  wire logic        clk_sys,
	input  wire logic        sample,
	input  wire logic [7:0]  lat,
	output logic             valid,
	output logic      [11:0] data
);
	logic [7:0] cnt_q = 8'h00;

	initial valid = 1'b0;
	initial data = 12'h000;
	// One result per request; between results the data lines toggle.
	always @(posedge clk_sys) begin
		valid <= 1'b0;
		data <= ~data;
		if (sample === 1'b1) begin
			cnt_q <= lat;
		end else if (cnt_q == 8'h01) begin
			cnt_q <= 8'h00;
			valid <= 1'b1;
			data <= 12'($urandom);
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end
endmodule
`default_nettype wire

// ===== sim/tb_adc_continuous_convert_bit_channel_control.sv
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module tb_adc_continuous_convert_bit_channel_control;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        ev_trig_i = 1'b0;
	logic        dma_rd_i = 1'b0;
	logic [1:0]  dma_ch_i = 2'h0;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wdata = 8'h00;
	logic [7:0]  lat = 8'h04;
	logic [7:0]  rdata, rv;
	logic [3:0]  ev_done_o, pos_o, dma_req_o, p;
	logic [2:0]  neg_o, q;
	logic [1:0]  cfg_o, m;
	logic        irq, sample_o, powered_o, res_valid_i;
	logic [11:0] res_data_i, dma_data_o, last_res;
	int          err_count = 0;
	int          check_count = 0;
	int          n;

	adcc_ctrl DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
		.ev_trig_i(ev_trig_i), .ev_done_o(ev_done_o), .sample_o(sample_o),
		.pos_o(pos_o), .neg_o(neg_o), .cfg_o(cfg_o), .powered_o(powered_o),
		.res_valid_i(res_valid_i), .res_data_i(res_data_i),
		.dma_req_o(dma_req_o), .dma_rd_i(dma_rd_i), .dma_ch_i(dma_ch_i),
		.dma_data_o(dma_data_o));
	adcc_fe_model FE (.clk_sys(clk_sys), .sample(sample_o), .lat(lat),
		.valid(res_valid_i), .data(res_data_i));

	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		if (res_valid_i === 1'b1)
			last_res <= res_data_i;
	end

	function automatic logic [7:0] insel(input logic [3:0] a,
		input logic [2:0] b);
		return {1'b0, a, b};
	endfunction
	function automatic logic [7:0] res_byte(input logic [11:0] r,
		input logic h);
		return h ? {4'h0, r[11:8]} : r[7:0];
	endfunction
	function automatic logic [7:0] ch_reg(input int c, input logic [1:0] s);
		return {adcc_pkg::CH_PAGE, 2'(c), s};
	endfunction

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic chk_res(input int c);
		rd_reg(ch_reg(c, adcc_pkg::SUB_RES_LOW), rv);
		chk(rv, res_byte(last_res, 1'b0));
		rd_reg(ch_reg(c, adcc_pkg::SUB_RES_HIGH), rv);
		chk(rv, res_byte(last_res, 1'b1));
	endtask
	// Bounded waits: a sample request, or completion events in mask e.
	task automatic wait_sample(output int k);
		for (k = 0; k < 200; k++) begin
			@(posedge clk_sys);
			#1;
			if (sample_o === 1'b1)
				return;
		end
		err_count++;
		$display("Error at %0t: no sample request", $time);
		finish_test();
	endtask
	task automatic wait_done(input logic [3:0] e);
		logic [3:0] s;
		s = 4'h0;
		for (int i = 0; i < 3000; i++) begin
			@(posedge clk_sys);
			#1;
			s = s | ev_done_o;
			if ((s & e) === e)
				return;
		end
		err_count++;
		$display("Error at %0t: no completion", $time);
		finish_test();
	endtask

	initial begin
		void'($urandom(8));
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rd_reg(adcc_pkg::A_FIRST_CTRL, rv);
		chk(rv, 8'h00);
		wr_reg(8'h07, 8'hff);
		rd_reg(8'h07, rv);
		chk(rv, 8'h00);
		$display("Test reset and unmapped done");
		// ------------------------------------------------------------
		// Free-running differential conversion on channel 0
		// ------------------------------------------------------------
		wr_reg(ch_reg(0, adcc_pkg::SUB_CFG), {6'h00, adcc_pkg::MODE_DIFF});
		wr_reg(ch_reg(0, adcc_pkg::SUB_INSEL), insel(4'h0, 3'h3));
		rd_reg(ch_reg(0, adcc_pkg::SUB_INSEL), rv);
		chk(rv, insel(4'h0, 3'h3));
		wr_reg(adcc_pkg::A_IRQ_MASK, 8'h01);
		wr_reg(adcc_pkg::A_SECOND_CTRL, 8'h08);
		lat <= 8'd40;
		wr_reg(adcc_pkg::A_FIRST_CTRL, 8'h01);
		wait_sample(n);
		chk(16'(n >= adcc_pkg::STARTUP_CLKS), 16'h1);
		chk(powered_o, 1'b1);
		chk({pos_o, 1'b0, neg_o, 6'h0, cfg_o},
			{4'h0, 1'b0, 3'h3, 6'h0, adcc_pkg::MODE_DIFF});
		for (int k = 0; k < 4; k++) begin
			lat <= 8'(30 + $urandom % 10);
			// Software waits for the completion event, clears the flag, then reads.
			wait_done(4'h1);
			chk(dma_req_o[0], 1'b1);
			rd_reg(adcc_pkg::A_DONE_FLAGS, rv);
			chk(rv[0], 1'b1);
			chk(irq, 1'b1);
			wr_reg(adcc_pkg::A_DONE_FLAGS, 8'h00);
			rd_reg(adcc_pkg::A_DONE_FLAGS, rv);
			chk(rv[0], 1'b1);
			wr_reg(adcc_pkg::A_DONE_FLAGS, 8'h01);
			rd_reg(adcc_pkg::A_DONE_FLAGS, rv);
			chk(rv[0], 1'b0);
			rd_reg(adcc_pkg::A_IRQ_STATUS, rv);
			chk(rv[0], 1'b1);
			chk_res(0);
			chk(irq, 1'b0);
			@(posedge clk_sys);
			dma_rd_i <= 1'b1;
			@(posedge clk_sys);
			dma_rd_i <= 1'b0;
			#1 chk(dma_data_o, last_res);
			chk(dma_req_o[0], 1'b0);
		end
		wait_done(4'h1);
		wait_done(4'h1);
		chk_res(0);
		rd_reg(adcc_pkg::A_DONE_FLAGS, rv);
		chk(rv[0], 1'b1);
		wr_reg(adcc_pkg::A_SECOND_CTRL, 8'h00);
		wait_done(4'h1);
		$display("Test free run done");
		// ------------------------------------------------------------
		// Start requests and event triggers on every channel
		// ------------------------------------------------------------
		for (int c = 0; c < 4; c++) begin
			p = 4'($urandom);
			q = 3'($urandom);
			m = c[0] ? adcc_pkg::MODE_SINGLE : adcc_pkg::MODE_DIFF;
			lat <= 8'(1 + $urandom % 8);
			wr_reg(ch_reg(c, adcc_pkg::SUB_CFG), {6'h00, m});
			wr_reg(ch_reg(c, adcc_pkg::SUB_INSEL), insel(p, q));
			wr_reg(adcc_pkg::A_FIRST_CTRL, 8'h01 | (8'h04 << c));
			wait_sample(n);
			chk({pos_o, 1'b0, neg_o, 6'h0, cfg_o},
				{p, 1'b0, c[0] ? 3'h0 : q, 6'h0, m});
			wait_done(4'(1 << c));
			chk_res(c);
		end
		wr_reg(adcc_pkg::A_DONE_FLAGS, 8'h0f);
		for (int j = 0; j < 2; j++) begin
			wr_reg(adcc_pkg::A_EVENT_CTRL, j ? 8'h09 : 8'h03);
			@(posedge clk_sys);
			ev_trig_i <= 1'b1;
			@(posedge clk_sys);
			ev_trig_i <= 1'b0;
			wait_done(j ? 4'h4 : 4'hf);
			rd_reg(adcc_pkg::A_DONE_FLAGS, rv);
			chk(rv[3:0], j ? 4'h4 : 4'hf);
			wr_reg(adcc_pkg::A_DONE_FLAGS, 8'h0f);
		end
		$display("Test starts and events done");
		finish_test();
	end
endmodule
`default_nettype wire
